// ===== acstx_backend.sv
// calibration sequencer, sample formatter and single-lane link framer
`timescale 1ns/10ps
`default_nettype none
module acstx_backend #(
   parameter int PWRUP_CYCLES = acstx_pkg::PWRUP_CYC,
   parameter int CAL_CYCLES = acstx_pkg::CAL_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic supplyOk,
   input wire logic clockOk,
   input wire logic sysrefPin,
   input wire logic syncN,
   input wire logic [13:0] coreSample,
   output logic coreCalibrating,
   output logic corePowerDown,
   output logic sampleEn,
   output logic [15:0] txWord,
   output logic [1:0] txCtrl,
   output logic txValid,
   output logic [2:0] outputSwingSetting,
   output logic [2:0] deemphasisSetting,
   output logic lmfcPulse
);
   import acstx_pkg::*;

   // ----------------------------------------------------------------
   // registers written by software
   // ----------------------------------------------------------------
   logic pwrDn_q;
   logic [1:0] inputClockDivideRatio_q;
   logic offBin_q;
   logic scrEn_q;
   logic [4:0] frames_q;
   acstx_test_t test_q;
   logic [7:0] rampStep_q;
   logic gateEn_q;
   logic divWrite;
   logic wrHit;

   assign wrHit = regWr;
   assign divWrite = regWr && (regAddr == ADDR_INPUT_CLOCK_DIVIDE_RATIO);

   always_ff @(posedge clk) begin
      if (srst) begin
         pwrDn_q <= 1'b0;
         inputClockDivideRatio_q <= INPUT_CLOCK_DIVIDE_RATIO_RST;
         offBin_q <= 1'b0;
         scrEn_q <= 1'b0;
         frames_q <= FRAMES_RST;
         test_q <= TST_OFF;
         rampStep_q <= RAMP_RST;
         gateEn_q <= 1'b0;
         outputSwingSetting <= 3'h0;
         deemphasisSetting <= 3'h0;
      end else if (wrHit) begin
         case (regAddr)
            ADDR_MODE: pwrDn_q <= regWdata[BIT_PWRDN];
            ADDR_INPUT_CLOCK_DIVIDE_RATIO: inputClockDivideRatio_q <= regWdata[1:0];
            ADDR_FORMAT: begin
               offBin_q <= regWdata[BIT_OFFBIN];
               scrEn_q <= regWdata[BIT_SCRAMBLE];
            end
            // frame count below the minimum is clamped
            ADDR_FRAMES: frames_q <= (regWdata[4:0] < FRAMES_MIN) ?
               FRAMES_MIN : regWdata[4:0];
            ADDR_TEST: test_q <= acstx_test_t'(regWdata[2:0]);
            ADDR_DRIVER: begin
               // both codes span 0..7, 0 meaning no de-emphasis
               outputSwingSetting <= regWdata[SWING_LSB +: 3];
               deemphasisSetting <= regWdata[DEEMPH_LSB +: 3];
            end
            ADDR_RAMP: rampStep_q <= regWdata;
            ADDR_SYSREF: gateEn_q <= regWdata[BIT_GATE];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers: a change counts once stages two and three agree
   // ----------------------------------------------------------------
   logic [3:0] pinIn;
   logic [3:0] syA_q;
   logic [3:0] syB_q;
   logic [3:0] syC_q;
   logic [3:0] pin_q;

   assign pinIn = {syncN, sysrefPin, clockOk, supplyOk};

   generate
      for (genvar g = 0; g < 4; g++) begin : gSync
         always_ff @(posedge clk) begin
            if (srst) begin
               syA_q[g] <= 1'b0;
               syB_q[g] <= 1'b0;
               syC_q[g] <= 1'b0;
               pin_q[g] <= 1'b0;
            end else begin
               syA_q[g] <= pinIn[g];
               syB_q[g] <= syA_q[g];
               syC_q[g] <= syB_q[g];
               if (syB_q[g] == syC_q[g]) begin
                  pin_q[g] <= syC_q[g];
               end
            end
         end
      end
   endgenerate

   logic suppliesValid;
   logic sysrefLvl;
   logic syncedHigh;
   logic sysrefOld_q;
   logic sysrefEdge;

   assign suppliesValid = pin_q[0] && pin_q[1];
   assign sysrefLvl = pin_q[2];
   assign syncedHigh = pin_q[3];
   // any rising edge counts, so one-shot, pulsed and periodic all work
   assign sysrefEdge = sysrefLvl && !sysrefOld_q && gateEn_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         sysrefOld_q <= 1'b0;
      end else begin
         sysrefOld_q <= sysrefLvl;
      end
   end

   // ----------------------------------------------------------------
   // sample clock divider: 1, 2, 4 or 8 device clocks per sample
   // ----------------------------------------------------------------
   logic [2:0] divCnt_q;
   logic [2:0] divLast;

   always_comb begin
      case (inputClockDivideRatio_q)
         2'h0: divLast = 3'h0;
         2'h1: divLast = 3'h1;
         2'h2: divLast = 3'h3;
         default: divLast = 3'h7;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst || divWrite) begin
         divCnt_q <= 3'h0;
         sampleEn <= 1'b0;
      end else begin
         sampleEn <= (divCnt_q == divLast);
         divCnt_q <= (divCnt_q == divLast) ? 3'h0 : divCnt_q + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // calibration sequencer, counts in sampling clock cycles
   // ----------------------------------------------------------------
   acstx_cal_t cal_q;
   logic [23:0] calCnt_q;
   logic calDone_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         cal_q <= CAL_WAITVALID;
         calCnt_q <= 24'h000000;
         calDone_q <= 1'b0;
         coreCalibrating <= 1'b0;
         corePowerDown <= 1'b0;
      end else begin
         case (cal_q)
            CAL_WAITVALID: begin
               calCnt_q <= 24'h000000;
               if (suppliesValid) begin
                  cal_q <= CAL_DELAY;
               end
            end
            CAL_DELAY: begin
               if (sampleEn) begin
                  calCnt_q <= calCnt_q + 24'h000001;
               end
               if (sampleEn && calCnt_q == 24'(PWRUP_CYCLES - 1)) begin
                  cal_q <= CAL_RUN;
                  calCnt_q <= 24'h000000;
                  coreCalibrating <= 1'b1;
                  calDone_q <= 1'b0;
               end
            end
            CAL_RUN: begin
               if (sampleEn) begin
                  calCnt_q <= calCnt_q + 24'h000001;
               end
               if (pwrDn_q) begin
                  cal_q <= CAL_PWRDN;
                  coreCalibrating <= 1'b0;
                  corePowerDown <= 1'b1;
               end else if (sampleEn &&
                            calCnt_q == 24'(CAL_CYCLES - 1)) begin
                  cal_q <= CAL_READY;
                  coreCalibrating <= 1'b0;
                  calDone_q <= 1'b1;
               end
            end
            CAL_READY: begin
               if (pwrDn_q) begin
                  cal_q <= CAL_PWRDN;
                  corePowerDown <= 1'b1;
               end
            end
            CAL_PWRDN: begin
               calDone_q <= 1'b0;
               calCnt_q <= 24'h000000;
               // return to normal operation recalibrates
               if (!pwrDn_q) begin
                  cal_q <= CAL_RUN;
                  corePowerDown <= 1'b0;
                  coreCalibrating <= 1'b1;
               end
            end
            default: cal_q <= CAL_WAITVALID;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sample formatting ahead of framing and scrambling
   // ----------------------------------------------------------------
   logic [15:0] fmtSample;

   // 14 bits left-justified in 16, tail bits zero; msb flip gives offset
   assign fmtSample = {coreSample[13] ^ offBin_q, coreSample[12:0],
      2'b00};

   // ----------------------------------------------------------------
   // frame and multiframe counters, realigned by sysref
   // ----------------------------------------------------------------
   logic [4:0] frameCnt_q;
   logic mfEnd;

   assign mfEnd = (frameCnt_q == frames_q);

   always_ff @(posedge clk) begin
      if (srst || divWrite) begin
         frameCnt_q <= 5'h00;
         lmfcPulse <= 1'b0;
      end else if (sysrefEdge) begin
         frameCnt_q <= 5'h00;
         lmfcPulse <= 1'b0;
      end else if (sampleEn) begin
         frameCnt_q <= mfEnd ? 5'h00 : frameCnt_q + 5'h01;
         lmfcPulse <= mfEnd;
      end else begin
         lmfcPulse <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // link state: code group sync, lane alignment, data
   // ----------------------------------------------------------------
   acstx_link_t link_q;
   logic [1:0] mfCnt_q;

   always_ff @(posedge clk) begin
      if (srst || divWrite) begin
         link_q <= LNK_CGS;
         mfCnt_q <= 2'h0;
      end else if (!syncedHigh) begin
         link_q <= LNK_CGS;
         mfCnt_q <= 2'h0;
      end else if (sampleEn) begin
         case (link_q)
            LNK_CGS: begin
               if (mfEnd) begin
                  link_q <= LNK_ILA;
               end
            end
            LNK_ILA: begin
               if (mfEnd) begin
                  mfCnt_q <= mfCnt_q + 2'h1;
                  if (mfCnt_q == ILA_MFRAMES && test_q != TST_ILA) begin
                     link_q <= LNK_DATA;
                  end
               end
            end
            LNK_DATA: ;
            default: link_q <= LNK_CGS;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // test sources and scrambler
   // ----------------------------------------------------------------
   logic [15:0] prbsWord;
   logic [15:0] ramp_q;
   logic [14:0] scr_q;
   logic [14:0] scrNext;
   logic [15:0] scrWord;

   acstx_prbs uPrbs (
      .clk(clk),
      .srst(srst),
      .restart(divWrite),
      .step(sampleEn),
      .poly(test_q[1:0]),
      .word(prbsWord)
   );

   always_ff @(posedge clk) begin
      if (srst || link_q != LNK_DATA) begin
         ramp_q <= 16'h0000;
      end else if (sampleEn) begin
         ramp_q <= ramp_q + {8'h00, rampStep_q};
      end
   end

   // self-synchronous 1 + x^14 + x^15, msb first
   always_comb begin
      scrNext = scr_q;
      scrWord = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         scrWord[i] = fmtSample[i] ^ scrNext[13] ^ scrNext[14];
         scrNext = {scrNext[13:0], scrWord[i]};
      end
   end

   always_ff @(posedge clk) begin
      if (srst || link_q != LNK_DATA) begin
         scr_q <= 15'h0000;
      end else if (sampleEn && scrEn_q) begin
         scr_q <= scrNext;
      end
   end

   // ----------------------------------------------------------------
   // lane word select; lane polarity is never inverted, and there is
   // no idle or transport test mode to choose
   // ----------------------------------------------------------------
   logic [15:0] wordD;
   logic [1:0] ctrlD;

   always_comb begin
      wordD = fmtSample;
      ctrlD = 2'b00;
      case (test_q)
         TST_D215: begin
            wordD = {SYM_D21_5, SYM_D21_5};
         end
         TST_K285: begin
            wordD = {SYM_K28_5, SYM_K28_5};
            ctrlD = 2'b11;
         end
         TST_PRBS7, TST_PRBS15, TST_PRBS23: begin
            wordD = prbsWord;
         end
         default: begin
            if (link_q == LNK_CGS) begin
               wordD = {SYM_K28_5, SYM_K28_5};
               ctrlD = 2'b11;
            end else if (link_q == LNK_ILA) begin
               // alignment data is never scrambled
               wordD = {3'h0, frameCnt_q, 6'h00, mfCnt_q};
               if (frameCnt_q == 5'h00) begin
                  wordD[15:8] = SYM_K28_0;
                  ctrlD[1] = 1'b1;
                  if (mfCnt_q == 2'h1) begin
                     wordD[7:0] = SYM_K28_4;
                     ctrlD[0] = 1'b1;
                  end
               end
               if (mfEnd) begin
                  wordD[7:0] = SYM_K28_3;
                  ctrlD[0] = 1'b1;
               end
            end else if (test_q == TST_RAMP) begin
               wordD = ramp_q;
            end else if (scrEn_q) begin
               wordD = scrWord;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         txWord <= 16'h0000;
         txCtrl <= 2'b00;
         txValid <= 1'b0;
      end else begin
         txValid <= sampleEn;
         if (sampleEn) begin
            txWord <= wordD;
            txCtrl <= ctrlD;
         end
      end
   end

   // ----------------------------------------------------------------
   // read port: data one cycle after the strobe, unmapped reads zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ADDR_MODE: regRdata <= {7'h00, pwrDn_q};
            ADDR_INPUT_CLOCK_DIVIDE_RATIO: regRdata <= {6'h00, inputClockDivideRatio_q};
            ADDR_FORMAT: regRdata <= {6'h00, scrEn_q, offBin_q};
            ADDR_FRAMES: regRdata <= {3'h0, frames_q};
            ADDR_TEST: regRdata <= {5'h00, test_q};
            ADDR_DRIVER: regRdata <= {2'h0, deemphasisSetting,
               outputSwingSetting};
            ADDR_RAMP: regRdata <= rampStep_q;
            ADDR_STATUS: regRdata <= {4'h0, syncedHigh,
               link_q == LNK_DATA, coreCalibrating, calDone_q};
            ADDR_SYSREF: regRdata <= {7'h00, gateEn_q};
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ===== acstx_pkg.sv
// constants shared by the converter back end: register map, fields, timing
package acstx_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_INPUT_CLOCK_DIVIDE_RATIO = 4'h1;
   localparam logic [3:0] ADDR_FORMAT = 4'h2;
   localparam logic [3:0] ADDR_FRAMES = 4'h3;
   localparam logic [3:0] ADDR_TEST = 4'h4;
   localparam logic [3:0] ADDR_DRIVER = 4'h5;
   localparam logic [3:0] ADDR_RAMP = 4'h6;
   localparam logic [3:0] ADDR_STATUS = 4'h7;
   localparam logic [3:0] ADDR_SYSREF = 4'h8;
   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int BIT_PWRDN = 0;
   localparam int BIT_OFFBIN = 0;
   localparam int BIT_SCRAMBLE = 1;
   localparam int BIT_GATE = 0;
   localparam int SWING_LSB = 0;
   localparam int DEEMPH_LSB = 3;
   localparam logic [1:0] INPUT_CLOCK_DIVIDE_RATIO_RST = 2'h0;
   localparam logic [4:0] FRAMES_RST = 5'h1F;
   localparam logic [4:0] FRAMES_MIN = 5'h08;
   localparam logic [7:0] RAMP_RST = 8'h01;
   // ----------------------------------------------------------------
   // link symbols
   // ----------------------------------------------------------------
   localparam logic [7:0] SYM_K28_5 = 8'hBC;
   localparam logic [7:0] SYM_D21_5 = 8'hB5;
   localparam logic [7:0] SYM_K28_0 = 8'h1C;
   localparam logic [7:0] SYM_K28_3 = 8'h7C;
   localparam logic [7:0] SYM_K28_4 = 8'h9C;
   localparam logic [1:0] ILA_MFRAMES = 2'h3;
   // ----------------------------------------------------------------
   // timing, in sampling clock cycles, power-up time also in ms
   // ----------------------------------------------------------------
   localparam int PWRUP_CYC = 8400000;
   localparam int CAL_CYC = 1000000;
   localparam int HOST_WAIT_CYC = 1500000;
   localparam real PWRUP_MS_AT_250M = 33.6;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CAL_WAITVALID = 3'b000,
      CAL_DELAY = 3'b001,
      CAL_RUN = 3'b010,
      CAL_READY = 3'b011,
      CAL_PWRDN = 3'b100
   } acstx_cal_t;
   typedef enum logic [1:0] {
      LNK_CGS = 2'b00,
      LNK_ILA = 2'b01,
      LNK_DATA = 2'b10
   } acstx_link_t;
   typedef enum logic [2:0] {
      TST_OFF = 3'b000,
      TST_D215 = 3'b001,
      TST_K285 = 3'b010,
      TST_ILA = 3'b011,
      TST_PRBS7 = 3'b100,
      TST_PRBS15 = 3'b101,
      TST_PRBS23 = 3'b110,
      TST_RAMP = 3'b111
   } acstx_test_t;
endpackage

// ===== acstx_prbs.sv
// prbs 7/15/23 generator, 16 bits per step
`timescale 1ns/10ps
`default_nettype none
module acstx_prbs (
   input wire logic clk,
   input wire logic srst,
   input wire logic restart,
   input wire logic step,
   input wire logic [1:0] poly,
   output logic [15:0] word
);
   import acstx_pkg::*;

   logic [22:0] state_q;
   logic [22:0] state_d;
   logic [15:0] word_d;
   logic fb;

   // ----------------------------------------------------------------
   // sixteen serial shifts per word, msb sent first
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      word_d = 16'h0000;
      fb = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         case (poly)
            2'h0: fb = state_d[6] ^ state_d[5];
            2'h1: fb = state_d[14] ^ state_d[13];
            default: fb = state_d[22] ^ state_d[17];
         endcase
         word_d[i] = fb;
         state_d = {state_d[21:0], fb};
      end
   end

   always_ff @(posedge clk) begin
      if (srst || restart) begin
         state_q <= 23'h7FFFFF;
         word <= 16'h0000;
      end else if (step) begin
         state_q <= state_d;
         word <= word_d;
      end
   end
endmodule
`default_nettype wire

// ===== acstx_backend_checker.sv
// port assertions for the converter back end
`timescale 1ns/10ps
`default_nettype none
module acstx_backend_checker #(
   parameter int PWRUP_CYCLES = 20,
   parameter int CAL_CYCLES = 10
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic coreCalibrating,
   input wire logic corePowerDown,
   input wire logic sampleEn,
   input wire logic txValid,
   input wire logic [2:0] outputSwingSetting,
   input wire logic [2:0] deemphasisSetting
);
   import acstx_pkg::*;
   int calCnt_q;
   // counts sample pulses, not clocks, so any divider setting is covered
   always_ff @(posedge clk) begin
      if (srst || !coreCalibrating) begin
         calCnt_q <= 0;
      end else if (sampleEn) begin
         calCnt_q <= calCnt_q + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_rd_idle_zero: assert property (
      !$past(regRd) |-> regRdata == 8'h00)
      else $error("read data not zero outside a read answer");
   a_unmapped_zero: assert property (
      regRd && regAddr > ADDR_SYSREF |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_frames_floor: assert property (
      regWr && regAddr == ADDR_FRAMES && regWdata < 8'h08 ##1
      regRd && regAddr == ADDR_FRAMES |=> regRdata == 8'h08)
      else $error("frame count below floor stored");
   a_cal_length: assert property (
      $fell(coreCalibrating) && !corePowerDown |-> calCnt_q == CAL_CYCLES)
      else $error("calibration run length wrong");
   a_pd_restart: assert property (
      $fell(corePowerDown) |-> ##[0:12] coreCalibrating)
      else $error("no calibration after power-down exit");
   // the mode bit is registered, then the sequencer acts: two cycles
   a_pd_write: assert property (
      regWr && regAddr == ADDR_MODE
      |-> ##2 corePowerDown == $past(regWdata[BIT_PWRDN], 2))
      else $error("power-down does not follow mode write");
   a_pd_no_cal: assert property (
      corePowerDown |-> !coreCalibrating)
      else $error("calibrating during power-down");
   a_driver_codes: assert property (
      $past(regWr) && $past(regAddr) == ADDR_DRIVER
      |-> {2'b00, deemphasisSetting, outputSwingSetting}
          == ($past(regWdata) & 8'h3F))
      else $error("driver codes do not follow write");
   a_valid_follows: assert property (
      sampleEn |=> txValid)
      else $error("lane word missing after sample");
   c_cal_end: cover property ($fell(coreCalibrating));
   c_pd_exit: cover property ($fell(corePowerDown));
   c_unmapped: cover property (regRd && regAddr > ADDR_SYSREF);
endmodule
bind acstx_backend acstx_backend_checker #(
   .PWRUP_CYCLES(PWRUP_CYCLES), .CAL_CYCLES(CAL_CYCLES)
) acstx_backend_checker_inst (.clk, .srst, .regAddr, .regWdata, .regWr,
   .regRd, .regRdata, .coreCalibrating, .corePowerDown, .sampleEn,
   .txValid, .outputSwingSetting, .deemphasisSetting);
`default_nettype wire

// ===== acstx_rx_model.sv
// receiver model: holds its sync request until control words arrive
`timescale 1ns/10ps
`default_nettype none
module acstx_rx_model #(
   parameter int SYNC_WORDS = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [15:0] txWord,
   input wire logic [1:0] txCtrl,
   input wire logic txValid,
   output logic syncN
);
   import acstx_pkg::*;
   int kCnt_q;
   // a slower receiver is modelled by raising the word count
   always_ff @(posedge clk) begin
      if (srst) begin
         kCnt_q <= 0;
      end else if (txValid && txCtrl == 2'b11 && kCnt_q < SYNC_WORDS
                   && txWord == {2{SYM_K28_5}}) begin
         kCnt_q <= kCnt_q + 1;
      end
   end
   assign syncN = (kCnt_q < SYNC_WORDS) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== acstx_backend_bench.sv
// self-checking bench for the converter back end
`timescale 1ns/10ps
`default_nettype none
module acstx_backend_bench;
   import acstx_pkg::*;
   localparam int CC = 10;
   logic clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, rdP = 1'b0;
   logic supplyOk = 1'b0, clockOk = 1'b0, sysrefPin = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic [13:0] coreSample = 14'h0000;
   logic [7:0] regRdata;
   logic coreCalibrating, corePowerDown, sampleEn, txValid, syncN;
   logic [15:0] txWord, e, x, q;
   logic [1:0] txCtrl;
   logic [2:0] swing, deemph;
   logic [15:0] expQ[$];
   int failures = 0, n_compared = 0, n, i;
   initial begin
      forever #50 clk = ~clk;
   end
   acstx_backend #(.PWRUP_CYCLES(20), .CAL_CYCLES(CC)) acstx_backend_inst (
      .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .supplyOk(supplyOk), .clockOk(clockOk), .sysrefPin(sysrefPin),
      .syncN(syncN), .coreSample(coreSample),
      .coreCalibrating(coreCalibrating), .corePowerDown(corePowerDown),
      .sampleEn(sampleEn), .txWord(txWord), .txCtrl(txCtrl),
      .txValid(txValid), .outputSwingSetting(swing),
      .deemphasisSetting(deemph), .lmfcPulse());
   acstx_rx_model acstx_rx_model_inst (.clk(clk), .srst(srst),
      .txWord(txWord), .txCtrl(txCtrl), .txValid(txValid), .syncN(syncN));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic tmo(string nm);
      failures++;
      $display("ERROR %s expected event seen timeout", nm);
      wrap_up;
   endtask
   // strobes stay up for back-to-back cycles; idle drops them
   task automatic wr(logic [3:0] a, logic [7:0] d);
      regRd <= 1'b0;
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] v, logic [7:0] m);
      regWr <= 1'b0;
      regRd <= 1'b1;
      regAddr <= a;
      expQ.push_back({m, v});
      @(posedge clk);
   endtask
   task automatic idle(int k);
      regWr <= 1'b0;
      regRd <= 1'b0;
      repeat (k) @(posedge clk);
   endtask
   task automatic waitCal(logic lvl, int lim);
      n = 0;
      while (coreCalibrating !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (coreCalibrating !== lvl) tmo("calibration");
      @(posedge clk);
   endtask
   task automatic seeW(logic [15:0] w, logic [1:0] c);
      @(negedge clk);
      chk("lane word", txWord, w);
      chk("lane ctrl", 16'(txCtrl), 16'(c));
      @(posedge clk);
   endtask
   // read answers are compared in the cycle after each read strobe
   always @(posedge clk) begin
      rdP <= regRd;
      if (rdP) begin
         q = expQ.pop_front();
         chk("regRdata", 16'(regRdata & q[15:8]), 16'(q[7:0]));
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(97379));
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      idle(2);
      rd(ADDR_FRAMES, 8'h1F, 8'hFF);
      rd(ADDR_FORMAT, 8'h00, 8'hFF);
      rd(ADDR_STATUS, 8'h00, 8'h07);
      rd(4'hC, 8'h00, 8'hFF);
      supplyOk <= 1'b1;
      clockOk <= 1'b1;
      idle(1);
      $display("reset values done");
      waitCal(1'b1, 40);
      chk("power-up delay", 16'(n >= 20), 16'h1);
      waitCal(1'b0, CC + 8);
      chk("cal length", 16'(n >= CC - 1 && n <= CC + 1), 16'h1);
      idle(300);
      rd(ADDR_STATUS, 8'h0D, 8'h0F);
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_MODE, 8'h00);
      idle(1);
      waitCal(1'b1, 12);
      rd(ADDR_STATUS, 8'h02, 8'h03);
      idle(1);
      waitCal(1'b0, CC + 8);
      rd(ADDR_STATUS, 8'h01, 8'h03);
      idle(400);
      $display("calibration done");
      for (i = 0; i < 16; i++) begin
         if (i == 8) wr(ADDR_FORMAT, 8'h01);
         coreSample <= 14'($urandom);
         idle(3);
         x = {coreSample[13] ^ (i >= 8), coreSample[12:0], 2'b00};
         seeW(x, 2'b00);
      end
      wr(ADDR_FORMAT, 8'h00);
      for (i = 1; i < 3; i++) begin
         wr(ADDR_TEST, 8'(i));
         idle(3);
         x = (i == 1) ? {2{SYM_D21_5}} : {2{SYM_K28_5}};
         seeW(x, 2'(3 * (i - 1)));
      end
      wr(ADDR_TEST, 8'h00);
      $display("data path done");
      for (i = 0; i < 8; i++) begin
         e = 16'((7 - i) * 8 + i);
         wr(ADDR_DRIVER, 8'(e));
         idle(1);
         @(negedge clk);
         chk("driver codes", {10'h000, deemph, swing}, e);
         @(posedge clk);
      end
      rd(ADDR_DRIVER, 8'h07, 8'hFF);
      wr(ADDR_FRAMES, 8'h03);
      rd(ADDR_FRAMES, 8'h08, 8'hFF);
      wr(ADDR_SYSREF, 8'h01);
      for (i = 0; i < 3; i++) begin
         sysrefPin <= 1'b1;
         idle(2);
         sysrefPin <= 1'b0;
         idle(40);
      end
      $display("settings done");
      wr(ADDR_INPUT_CLOCK_DIVIDE_RATIO, 8'h02);
      rd(ADDR_STATUS, 8'h00, 8'h04);
      idle(8);
      for (i = 0; i < 9 && sampleEn !== 1'b1; i++) @(negedge clk);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (sampleEn !== 1'b1 && n < 9);
      chk("sample spacing", 16'(n), 16'h0004);
      @(posedge clk);
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_MODE, 8'h00);
      idle(1);
      waitCal(1'b1, 20);
      waitCal(1'b0, CC * 4 + 20);
      rd(ADDR_STATUS, 8'h01, 8'h03);
      idle(2);
      srst <= 1'b1;
      idle(3);
      srst <= 1'b0;
      idle(2);
      rd(ADDR_FORMAT, 8'h00, 8'hFF);
      rd(ADDR_INPUT_CLOCK_DIVIDE_RATIO, 8'h00, 8'hFF);
      idle(3);
      $display("divider and reset done");
      wrap_up;
   end
endmodule
`default_nettype wire
